/* File: rtl/oad_decoder.sv */
// Opcode fetch, addressing-mode decode and effective-address formation.
`timescale 1ns/100ps
module oad_decoder
  import oad_pkg::*;
#(
  parameter int unsigned CYCLE_W = 8
)
(
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  // Byte-wide memory read port, data sampled at the end of the strobe cycle.
  output logic [15:0]       mem_addr_o,
  output logic              mem_rd_o,
  input  wire logic [7:0]   mem_data_i,
  // Core register values used for operand and address formation.
  input  wire logic [7:0]   acc_a_i,
  input  wire logic [7:0]   acc_b_i,
  input  wire logic [15:0]  index_i,
  input  wire logic [15:0]  stack_i,
  input  wire logic         pc_load_i,
  input  wire logic [15:0]  pc_load_val_i,
  // Decoded instruction.
  output logic              decode_valid_o,
  output logic [7:0]        opcode_o,
  output oad_mode_e         mode_o,
  output logic [1:0]        length_o,
  output logic              acc_sel_o,
  output logic [15:0]       ea_o,
  output logic [15:0]       operand_o,
  output logic              wide_imm_o,
  output logic [15:0]       pc_o,
  output logic [CYCLE_W-1:0] cycles_o,
  // Condition-code update.
  input  wire logic         alu_valid_i,
  input  wire oad_alu_e     alu_op_i,
  input  wire logic [7:0]   alu_a_i,
  input  wire logic [7:0]   alu_b_i,
  input  wire oad_flagctl_s flag_ctl_i,
  output logic [7:0]        alu_result_o,
  output oad_ccr_s          ccr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and length decode from the opcode column.
  function automatic oad_mode_e decode_mode(input logic [7:0] op);
    unique case (op[7:4])
      4'h0, 4'h1, 4'h3: decode_mode = OAD_M_IMP;
      4'h2:             decode_mode = OAD_M_REL;
      4'h4, 4'h5:       decode_mode = OAD_M_ACC;
      4'h6, 4'hA, 4'hE: decode_mode = OAD_M_IDX;
      4'h7, 4'hB, 4'hF: decode_mode = OAD_M_EXT;
      4'h9, 4'hD:       decode_mode = OAD_M_DIR;
      4'h8, 4'hC:       decode_mode = (op == OP_BRANCH_SUB) ? OAD_M_REL
                                                            : OAD_M_IMM;
    endcase
  endfunction

  function automatic logic is_wide(input logic [7:0] op);
    is_wide = (op == OP_CMP_INDEX) || (op == OP_LOAD_SP) ||
              (op == OP_LOAD_IX);
  endfunction

  function automatic logic [1:0] decode_len(input oad_mode_e m,
                                            input logic wide);
    unique case (m)
      OAD_M_ACC, OAD_M_IMP:            decode_len = LEN_ONE;
      OAD_M_DIR, OAD_M_IDX, OAD_M_REL: decode_len = LEN_TWO;
      OAD_M_EXT:                       decode_len = LEN_THREE;
      OAD_M_IMM: decode_len = wide ? LEN_THREE : LEN_TWO;
      default:                         decode_len = LEN_ONE;
    endcase
  endfunction

  // Index plus unsigned offset, carry of the low byte into the high byte.
  function automatic logic [15:0] add_index(input logic [15:0] base,
                                            input logic [7:0] off);
    logic [8:0] lo;
    logic [7:0] hi;
    lo = {1'b0, base[7:0]} + {1'b0, off};
    hi = base[15:8] + {7'h00, lo[8]};
    add_index = {hi, lo[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.
  oad_state_e   state;
  oad_state_e   next_state;
  logic [15:0]  pc;
  logic [7:0]   opcode;
  logic [7:0]   byte2;
  oad_mode_e    mode;
  logic [1:0]   len;
  logic         wide;
  logic [15:0]  temp_addr;
  logic [CYCLE_W-1:0] cyc_cnt;
  oad_ccr_s     ccr;

  // Decode of the byte arriving in the opcode cycle.
  wire oad_mode_e  opc_mode = decode_mode(mem_data_i);
  wire             opc_wide = is_wide(mem_data_i);
  wire logic [1:0] opc_len  = decode_len(opc_mode, opc_wide);

  // Address of following bytes and of the next opcode.
  wire [15:0] pc_plus1 = pc + 16'h0001;
  wire [15:0] pc_plus2 = pc + REL_BIAS;
  wire [15:0] pc_next  = pc + {14'h0000, len};

  // Effective address for modes that need no third byte.
  wire [15:0] rel_ea  = pc_plus2 + {{8{byte2[7]}}, byte2};
  wire [15:0] idx_ea  = add_index(index_i, byte2);
  wire [15:0] dir_ea  = {BYTE_ZERO, byte2};
  wire [15:0] imp_ea  = (opcode[7:4] == 4'h3) ? stack_i : index_i;
  wire [7:0]  acc_val = opcode[4] ? acc_b_i : acc_a_i;

  // Next-state selection along the byte sequence.
  always_comb
  begin
    unique case (state)
      OAD_S_FETCH: next_state = OAD_S_OPC;
      OAD_S_OPC:   next_state = (opc_len == LEN_ONE) ? OAD_S_EXEC : OAD_S_B2;
      OAD_S_B2:    next_state = (len == LEN_THREE) ? OAD_S_B3 : OAD_S_EXEC;
      OAD_S_B3:    next_state = OAD_S_EXEC;
      OAD_S_EXEC:  next_state = OAD_S_FETCH;
      default:     next_state = OAD_S_FETCH;
    endcase
  end

  // Memory strobe and address for each fetch.
  wire        next_rd   = (state == OAD_S_FETCH) ||
                          (state == OAD_S_OPC && opc_len != LEN_ONE) ||
                          (state == OAD_S_B2 && len == LEN_THREE);
  wire [15:0] next_addr = (state == OAD_S_FETCH) ? pc :
                          (state == OAD_S_OPC)   ? pc_plus1 : pc_plus2;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= OAD_S_FETCH;
      mem_rd_o   <= 1'b0;
      mem_addr_o <= PC_RESET;
    end
    else
    begin
      state      <= next_state;
      mem_rd_o   <= next_rd;
      mem_addr_o <= next_rd ? next_addr : mem_addr_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction bytes, mode, length and program counter.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc     <= PC_RESET;
      opcode <= BYTE_ZERO;
      byte2  <= BYTE_ZERO;
      mode   <= OAD_M_IMP;
      len    <= LEN_ONE;
      wide   <= 1'b0;
    end
    else
    begin
      if (state == OAD_S_OPC)
      begin
        opcode <= mem_data_i;
        mode   <= opc_mode;
        len    <= opc_len;
        wide   <= opc_wide;
      end
      if (state == OAD_S_B2)
        byte2 <= mem_data_i;
      if (state == OAD_S_EXEC)
        pc <= pc_load_i ? pc_load_val_i : pc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temporary effective address; the index input is only read.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      temp_addr <= WORD_ZERO;
    else if (state == OAD_S_B2)
      temp_addr <= WORD_ZERO;
    else if (state == OAD_S_B3)
      temp_addr <= {byte2, mem_data_i};
    else if (state == OAD_S_EXEC && mode != OAD_M_EXT && mode != OAD_M_IMM)
      temp_addr <= (mode == OAD_M_IDX) ? idx_ea :
                   (mode == OAD_M_DIR) ? dir_ea :
                   (mode == OAD_M_REL) ? rel_ea :
                   (mode == OAD_M_IMP) ? imp_ea : WORD_ZERO;
    else if (state == OAD_S_EXEC && mode == OAD_M_IMM && !wide)
      temp_addr <= {BYTE_ZERO, byte2};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus machine cycles spent on the current instruction.
  logic [6:0] bus_div;
  wire        bus_tick = (bus_div == 7'(MCLK_PER_BUS - 1));

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_div <= 7'h00;
      cyc_cnt <= '0;
    end
    else
    begin
      bus_div <= bus_tick ? 7'h00 : bus_div + 7'h01;
      if (state == OAD_S_EXEC)
        cyc_cnt <= '0;
      else if (bus_tick)
        cyc_cnt <= cyc_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded outputs, registered when execution starts and held, but pc_o follows the program counter every clock; decode_valid_o marks them for one clock.
  wire is_exec = (state == OAD_S_EXEC);

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decode_valid_o <= 1'b0;
      opcode_o       <= BYTE_ZERO;
      mode_o         <= OAD_M_IMP;
      length_o       <= LEN_ONE;
      acc_sel_o      <= 1'b0;
      ea_o           <= WORD_ZERO;
      operand_o      <= WORD_ZERO;
      wide_imm_o     <= 1'b0;
      pc_o           <= PC_RESET;
      cycles_o       <= '0;
    end
    else
    begin
      decode_valid_o <= is_exec;
      pc_o           <= pc;
      if (is_exec)
      begin
        opcode_o   <= opcode;
        mode_o     <= mode;
        length_o   <= len;
        acc_sel_o  <= opcode[4];
        wide_imm_o <= wide;
        cycles_o   <= cyc_cnt;
        ea_o       <= (mode == OAD_M_EXT) ? temp_addr :
                      (mode == OAD_M_IMM) ? pc_plus1 :
                      (mode == OAD_M_IDX) ? idx_ea :
                      (mode == OAD_M_DIR) ? dir_ea :
                      (mode == OAD_M_REL) ? rel_ea :
                      (mode == OAD_M_IMP) ? imp_ea : WORD_ZERO;
        operand_o  <= (mode == OAD_M_ACC) ? {BYTE_ZERO, acc_val} :
                      (mode == OAD_M_IMM) ? (wide ? temp_addr
                                                  : {BYTE_ZERO, byte2})
                                          : WORD_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition-code register.
  logic [7:0] next_result;
  oad_ccr_s   next_ccr;

  oad_flag_unit u_flags (
    .a_i      (alu_a_i),
    .b_i      (alu_b_i),
    .op_i     (alu_op_i),
    .ctl_i    (flag_ctl_i),
    .ccr_i    (ccr),
    .result_o (next_result),
    .ccr_o    (next_ccr)
  );

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ccr          <= CCR_RESET;
      alu_result_o <= BYTE_ZERO;
    end
    else if (alu_valid_i)
    begin
      ccr          <= next_ccr;
      alu_result_o <= next_result;
    end
  end

  assign ccr_o = ccr;

endmodule

/* File: rtl/oad_pkg.sv */
// Shared constants, types and encodings for the operand addressing decoder.
package oad_pkg;

  // Instruction set size and instruction lengths in bytes.
  localparam int unsigned NUM_INSTR   = 72;
  localparam logic [1:0]  LEN_ONE     = 2'h1;
  localparam logic [1:0]  LEN_TWO     = 2'h2;
  localparam logic [1:0]  LEN_THREE   = 2'h3;

  // Reset values.
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;

  // Opcodes that take a two-byte immediate operand, and the branch-to-subroutine opcode decoded as relative.
  localparam logic [7:0]  OP_CMP_INDEX = 8'h8C;
  localparam logic [7:0]  OP_LOAD_SP   = 8'h8E;
  localparam logic [7:0]  OP_LOAD_IX   = 8'hCE;
  localparam logic [7:0]  OP_BRANCH_SUB = 8'h8D;

  // Relative branches are based on the address of the following opcode.
  localparam logic [15:0] REL_BIAS    = 16'h0002;

  // Timing: bus machine cycle and system clock period.
  localparam int unsigned BUS_CYCLE_NS = 1000;
  localparam int unsigned MCLK_NS      = 10;
  localparam int unsigned MCLK_PER_BUS = BUS_CYCLE_NS / MCLK_NS;

  // Data bit positions of the half carry and the carry.
  localparam int unsigned HALF_BIT  = 3;
  localparam int unsigned CARRY_BIT = 7;

  typedef enum logic [2:0] {
    OAD_M_ACC  = 3'h0,
    OAD_M_IMM  = 3'h1,
    OAD_M_DIR  = 3'h2,
    OAD_M_EXT  = 3'h3,
    OAD_M_IDX  = 3'h4,
    OAD_M_IMP  = 3'h5,
    OAD_M_REL  = 3'h6
  } oad_mode_e;

  // Gray codes along fetch -> opcode -> byte2 -> byte3 -> execute.
  typedef enum logic [2:0] {
    OAD_S_FETCH = 3'b000,
    OAD_S_OPC   = 3'b001,
    OAD_S_B2    = 3'b011,
    OAD_S_B3    = 3'b010,
    OAD_S_EXEC  = 3'b110
  } oad_state_e;

  // Four ways an instruction may update a condition flag.
  typedef enum logic [1:0] {
    OAD_F_KEEP = 2'h0,
    OAD_F_CLR  = 2'h1,
    OAD_F_SET  = 2'h2,
    OAD_F_TEST = 2'h3
  } oad_fmode_e;

  typedef enum logic [2:0] {
    OAD_A_ADD  = 3'h0,
    OAD_A_ADC  = 3'h1,
    OAD_A_SUB  = 3'h2,
    OAD_A_SBC  = 3'h3,
    OAD_A_AND  = 3'h4,
    OAD_A_OR   = 3'h5,
    OAD_A_EOR  = 3'h6,
    OAD_A_PASS = 3'h7
  } oad_alu_e;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic v;
    logic c;
  } oad_ccr_s;

  typedef struct packed {
    oad_fmode_e h;
    oad_fmode_e i;
    oad_fmode_e n;
    oad_fmode_e z;
    oad_fmode_e v;
    oad_fmode_e c;
  } oad_flagctl_s;

  localparam oad_ccr_s CCR_RESET = 6'h10;

endpackage

/* File: rtl/oad_flag_unit.sv */
// Arithmetic result and condition-code update for one operation.
`timescale 1ns/100ps
module oad_flag_unit
  import oad_pkg::*;
(
  input  wire logic [7:0]   a_i,
  input  wire logic [7:0]   b_i,
  input  wire oad_alu_e     op_i,
  input  wire oad_flagctl_s ctl_i,
  input  wire oad_ccr_s     ccr_i,
  output logic [7:0]        result_o,
  output oad_ccr_s          ccr_o
);

  // Carry in applies only to the with-carry forms.
  wire       cin    = (op_i == OAD_A_ADC || op_i == OAD_A_SBC) ? ccr_i.c : 1'b0;
  wire       is_sub = (op_i == OAD_A_SUB || op_i == OAD_A_SBC);
  wire [8:0] sum9   = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
  wire [8:0] dif9   = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
  wire [4:0] hsum   = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
  wire [4:0] hdif   = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin};
  wire       is_ar  = (op_i <= OAD_A_SBC);

  // Result selection for every operation.
  always_comb
  begin
    unique case (op_i)
      OAD_A_ADD, OAD_A_ADC: result_o = sum9[7:0];
      OAD_A_SUB, OAD_A_SBC: result_o = dif9[7:0];
      OAD_A_AND:            result_o = a_i & b_i;
      OAD_A_OR:             result_o = a_i | b_i;
      OAD_A_EOR:            result_o = a_i ^ b_i;
      OAD_A_PASS:           result_o = b_i;
    endcase
  end

  // Flag tests: half carry from bit 3, carry from bit 7, overflow, sign, zero.
  wire t_h = is_sub ? hdif[4] : hsum[4];
  wire t_c = is_ar & (is_sub ? dif9[8] : sum9[8]);
  wire t_v = is_ar & (is_sub ? (a_i[CARRY_BIT] != b_i[CARRY_BIT])
                             : (a_i[CARRY_BIT] == b_i[CARRY_BIT]))
           & (result_o[CARRY_BIT] != a_i[CARRY_BIT]);
  wire t_n = result_o[CARRY_BIT];
  wire t_z = (result_o == BYTE_ZERO);

  // Apply one of the four update ways to a flag.
  function automatic logic upd(input oad_fmode_e m, input logic old,
                               input logic test);
    unique case (m)
      OAD_F_KEEP: upd = old;
      OAD_F_CLR:  upd = 1'b0;
      OAD_F_SET:  upd = 1'b1;
      OAD_F_TEST: upd = test;
    endcase
  endfunction

  // The interrupt mask has no arithmetic test; a test leaves it as it is.
  assign ccr_o.h = upd(ctl_i.h, ccr_i.h, t_h);
  assign ccr_o.i = upd(ctl_i.i, ccr_i.i, ccr_i.i);
  assign ccr_o.n = upd(ctl_i.n, ccr_i.n, t_n);
  assign ccr_o.z = upd(ctl_i.z, ccr_i.z, t_z);
  assign ccr_o.v = upd(ctl_i.v, ccr_i.v, t_v);
  assign ccr_o.c = upd(ctl_i.c, ccr_i.c, t_c);

endmodule

/* File: bench/oad_decoder_checker.sv */
// Concurrent checks on the ports of the operand addressing decoder.
`timescale 1ns/100ps
module oad_decoder_checker
  import oad_pkg::*;
#(
  parameter int unsigned CYCLE_W = 8
)
(
  input wire logic         mclk_i,
  input wire logic         rstn_i,
  input wire logic [15:0]  mem_addr_o,
  input wire logic         mem_rd_o,
  input wire logic         pc_load_i,
  input wire logic         decode_valid_o,
  input wire oad_mode_e    mode_o,
  input wire logic [1:0]   length_o,
  input wire logic [15:0]  ea_o,
  input wire logic         wide_imm_o,
  input wire logic [15:0]  pc_o,
  input wire logic         alu_valid_i,
  input wire oad_alu_e     alu_op_i,
  input wire logic [7:0]   alu_a_i,
  input wire logic [7:0]   alu_b_i,
  input wire oad_flagctl_s flag_ctl_i,
  input wire oad_ccr_s     ccr_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////////
  // Reference carries of an addition, out of bit 7 and out of bit 3.
  logic [8:0] sum_w;
  logic [4:0] nib_w;
  logic       carry_w;
  logic       half_w;
  assign sum_w   = {1'b0, alu_a_i} + {1'b0, alu_b_i};
  assign nib_w   = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
  assign carry_w = sum_w[8];
  assign half_w  = nib_w[4];

  ////////////////////////////////////////////////////////////////////////////
  // Fetch order and decode lengths per mode.
  a_fetch_in_order: assert property (mem_rd_o && $past(mem_rd_o)
    |-> mem_addr_o == $past(mem_addr_o) + 16'h0001)
    else $error("consecutive reads not at consecutive addresses");
  a_next_opcode: assert property (decode_valid_o && !$past(pc_load_i)
    |=> mem_rd_o && mem_addr_o == $past(pc_o) + {14'h0, $past(length_o)})
    else $error("next opcode not fetched at pc plus length");
  a_valid_single: assert property (decode_valid_o
    |=> !decode_valid_o[*2])
    else $error("decode valid pulse too long or too close");
  a_acc_one_byte: assert property (decode_valid_o && mode_o == OAD_M_ACC
    |-> length_o == LEN_ONE)
    else $error("accumulator mode length wrong");
  a_imm_width: assert property (decode_valid_o && mode_o == OAD_M_IMM
    |-> length_o == (wide_imm_o ? LEN_THREE : LEN_TWO))
    else $error("immediate length does not match operand width");
  a_dir_page_zero: assert property (decode_valid_o && mode_o == OAD_M_DIR
    |-> ea_o[15:8] == 8'h00 && length_o == LEN_TWO)
    else $error("direct address outside page zero or bad length");
  a_ext_three: assert property (decode_valid_o && mode_o == OAD_M_EXT
    |-> length_o == LEN_THREE)
    else $error("extended mode length wrong");
  a_idx_two: assert property (decode_valid_o && mode_o == OAD_M_IDX
    |-> length_o == LEN_TWO)
    else $error("indexed mode length wrong");
  a_imp_one: assert property (decode_valid_o && mode_o == OAD_M_IMP
    |-> length_o == LEN_ONE)
    else $error("implied mode length wrong");
  a_rel_two: assert property (decode_valid_o && mode_o == OAD_M_REL
    |-> length_o == LEN_TWO)
    else $error("relative mode length wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Condition-code updates.
  a_carry_bit7: assert property (alu_valid_i && alu_op_i == OAD_A_ADD
    && flag_ctl_i.c == OAD_F_TEST |=> ccr_o.c == $past(carry_w))
    else $error("carry flag not carry out of bit 7");
  a_half_bit3: assert property (alu_valid_i && alu_op_i == OAD_A_ADD
    && flag_ctl_i.h == OAD_F_TEST |=> ccr_o.h == $past(half_w))
    else $error("half carry not carry out of bit 3");
  a_flag_cleared: assert property (alu_valid_i
    && flag_ctl_i.v == OAD_F_CLR |=> !ccr_o.v)
    else $error("cleared flag still set");
  a_flag_forced: assert property (alu_valid_i
    && flag_ctl_i.n == OAD_F_SET |=> ccr_o.n)
    else $error("set flag still clear");
  a_flag_held: assert property (alu_valid_i
    && flag_ctl_i.z == OAD_F_KEEP |=> $stable(ccr_o.z))
    else $error("kept flag changed");

  c_ext_decode: cover property (decode_valid_o && mode_o == OAD_M_EXT);
  c_idx_decode: cover property (decode_valid_o && mode_o == OAD_M_IDX);
  c_add_carry: cover property (alu_valid_i && alu_op_i == OAD_A_ADD
    && carry_w);
endmodule

bind oad_decoder oad_decoder_checker #(.CYCLE_W(CYCLE_W)) chk_inst (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .pc_load_i(pc_load_i),
  .decode_valid_o(decode_valid_o), .mode_o(mode_o), .length_o(length_o),
  .ea_o(ea_o), .wide_imm_o(wide_imm_o), .pc_o(pc_o),
  .alu_valid_i(alu_valid_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i),
  .alu_b_i(alu_b_i), .flag_ctl_i(flag_ctl_i), .ccr_o(ccr_o));

/* File: bench/oad_mem_model.sv */
// Byte-wide program memory answering reads within the strobe cycle.
`timescale 1ns/100ps
module oad_mem_model
(
  input  wire logic        mclk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  output logic [7:0]       data_o
);
  logic [7:0] mem [0:65535];

  initial data_o = 8'h00;

  // Data stands from mid-strobe through the next edge; otherwise it toggles
  // so that a late or early sample cannot pass by luck.
  always @(negedge mclk_i)
  begin
    if (rd_i)
      data_o <= mem[addr_i];
    else
      data_o <= ~data_o;
  end
endmodule

/* File: bench/test_oad_decoder.sv */
// Self-checking testbench for the operand addressing decoder.
`timescale 1ns/100ps
module test_oad_decoder
  import oad_pkg::*;
;
  typedef struct {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    oad_mode_e  mode;
    logic [1:0] len;
  } oad_row_s;
  typedef struct {
    oad_alu_e     op;
    logic [7:0]   a;
    logic [7:0]   b;
    logic [7:0]   res;
    oad_flagctl_s ctl;
    logic [5:0]   ccr;
  } oad_alu_row_s;

  localparam logic [15:0] IDX_VAL = 16'h1234;
  localparam logic [15:0] STK_VAL = 16'h4000;
  localparam logic [7:0]  ACC_A   = 8'h5A;
  localparam logic [7:0]  ACC_B   = 8'hA5;
  localparam oad_flagctl_s FT = '{OAD_F_TEST, OAD_F_KEEP, OAD_F_TEST,
                                  OAD_F_TEST, OAD_F_TEST, OAD_F_TEST};
  localparam oad_flagctl_s FL = '{OAD_F_KEEP, OAD_F_KEEP, OAD_F_TEST,
                                  OAD_F_TEST, OAD_F_TEST, OAD_F_TEST};
  localparam oad_flagctl_s FC = '{default: OAD_F_CLR};
  localparam oad_flagctl_s FS = '{default: OAD_F_SET};
  localparam oad_flagctl_s FK = '{default: OAD_F_KEEP};

  ////////////////////////////////////////////////////////////////////////////
  // Program rows and arithmetic rows with their expected outcomes.
  oad_row_s rows [14] = '{
    '{8'h4F, 8'h00, 8'h00, OAD_M_ACC, LEN_ONE},
    '{8'h5C, 8'h00, 8'h00, OAD_M_ACC, LEN_ONE},
    '{8'h86, 8'h12, 8'h00, OAD_M_IMM, LEN_TWO},
    '{8'h8E, 8'h12, 8'h34, OAD_M_IMM, LEN_THREE},
    '{8'hCE, 8'hAB, 8'hCD, OAD_M_IMM, LEN_THREE},
    '{8'h8C, 8'h00, 8'h01, OAD_M_IMM, LEN_THREE},
    '{8'h96, 8'hFF, 8'h00, OAD_M_DIR, LEN_TWO},
    '{8'hB6, 8'h12, 8'h34, OAD_M_EXT, LEN_THREE},
    '{8'hA6, 8'hFF, 8'h00, OAD_M_IDX, LEN_TWO},
    '{8'h08, 8'h00, 8'h00, OAD_M_IMP, LEN_ONE},
    '{8'h30, 8'h00, 8'h00, OAD_M_IMP, LEN_ONE},
    '{8'h20, 8'h7F, 8'h00, OAD_M_REL, LEN_TWO},
    '{8'h20, 8'h80, 8'h00, OAD_M_REL, LEN_TWO},
    '{8'h8D, 8'h10, 8'h00, OAD_M_REL, LEN_TWO}};
  oad_alu_row_s alus [13] = '{
    '{OAD_A_ADD, 8'h08, 8'h08, 8'h10, FT, 6'h30},
    '{OAD_A_ADD, 8'h80, 8'h80, 8'h00, FT, 6'h17},
    '{OAD_A_ADC, 8'h01, 8'h01, 8'h03, FT, 6'h10},
    '{OAD_A_SUB, 8'h00, 8'h01, 8'hFF, FT, 6'h39},
    '{OAD_A_SBC, 8'h05, 8'h01, 8'h03, FT, 6'h10},
    '{OAD_A_SUB, 8'h80, 8'h01, 8'h7F, FT, 6'h32},
    '{OAD_A_AND, 8'hF0, 8'h0F, 8'h00, FL, 6'h34},
    '{OAD_A_OR,  8'h80, 8'h01, 8'h81, FL, 6'h38},
    '{OAD_A_EOR, 8'hFF, 8'hFF, 8'h00, FL, 6'h34},
    '{OAD_A_PASS, 8'h00, 8'h7F, 8'h7F, FL, 6'h30},
    '{OAD_A_ADD, 8'h80, 8'h80, 8'h00, FC, 6'h00},
    '{OAD_A_ADD, 8'h80, 8'h80, 8'h00, FS, 6'h3F},
    '{OAD_A_ADD, 8'h80, 8'h80, 8'h00, FK, 6'h3F}};

  logic         mclk_i;
  logic         rstn_i;
  logic [15:0]  mem_addr_o;
  logic         mem_rd_o;
  logic [7:0]   mem_data_i;
  logic         pc_load_i;
  logic [15:0]  pc_load_val_i;
  logic         decode_valid_o;
  logic [7:0]   opcode_o;
  oad_mode_e    mode_o;
  logic [1:0]   length_o;
  logic         acc_sel_o;
  logic [15:0]  ea_o;
  logic [15:0]  operand_o;
  logic         wide_imm_o;
  logic [15:0]  pc_o;
  logic [7:0]   cycles_o;
  logic         alu_valid_i;
  oad_alu_e     alu_op_i;
  logic [7:0]   alu_a_i;
  logic [7:0]   alu_b_i;
  oad_flagctl_s flag_ctl_i;
  logic [7:0]   alu_result_o;
  oad_ccr_s     ccr_o;
  int           mismatches;
  int           comparisons;
  int           cycle_cnt;
  logic [15:0]  pc;

  oad_decoder #(.CYCLE_W(8)) oad_decoder_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i), .acc_a_i(ACC_A),
    .acc_b_i(ACC_B), .index_i(IDX_VAL), .stack_i(STK_VAL),
    .pc_load_i(pc_load_i), .pc_load_val_i(pc_load_val_i),
    .decode_valid_o(decode_valid_o), .opcode_o(opcode_o), .mode_o(mode_o),
    .length_o(length_o), .acc_sel_o(acc_sel_o), .ea_o(ea_o),
    .operand_o(operand_o), .wide_imm_o(wide_imm_o), .pc_o(pc_o),
    .cycles_o(cycles_o), .alu_valid_i(alu_valid_i), .alu_op_i(alu_op_i),
    .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .flag_ctl_i(flag_ctl_i),
    .alu_result_o(alu_result_o), .ccr_o(ccr_o));
  oad_mem_model oad_mem_model_inst (.mclk_i(mclk_i), .addr_i(mem_addr_o),
    .rd_i(mem_rd_o), .data_o(mem_data_i));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, cycle limit and shared helpers.
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    cycle_cnt++;
    if (cycle_cnt == 2000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask

  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask

  task automatic wait_valid();
    int n;
    step();
    for (n = 0; n < 40 && decode_valid_o !== 1'b1; n++)
      step();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [15:0] exp_ea(oad_row_s r, logic [15:0] p);
    case (r.mode)
      OAD_M_IMM: return p + 16'h0001;
      OAD_M_DIR: return {8'h00, r.b2};
      OAD_M_EXT: return {r.b2, r.b3};
      OAD_M_IDX: return IDX_VAL + {8'h00, r.b2};
      OAD_M_IMP: return (r.op[7:4] == 4'h3) ? STK_VAL : IDX_VAL;
      OAD_M_REL: return p + 16'h0002 + {{8{r.b2[7]}}, r.b2};
      default:   return 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, program rows, arithmetic rows, reset again.
  initial
  begin
    {rstn_i, pc_load_i, alu_valid_i, alu_a_i, alu_b_i} = '0;
    {mismatches, comparisons, cycle_cnt} = '0;
    pc_load_val_i = 16'h0000;
    alu_op_i = OAD_A_ADD;
    flag_ctl_i = FK;
    for (int i = 0; i < 256; i++)
      oad_mem_model_inst.mem[i] = 8'h01;
    pc = PC_RESET;
    foreach (rows[i])
    begin
      oad_mem_model_inst.mem[pc] = rows[i].op;
      oad_mem_model_inst.mem[pc + 16'h0001] = rows[i].b2;
      oad_mem_model_inst.mem[pc + 16'h0002] = rows[i].b3;
      pc = pc + {14'h0, rows[i].len};
    end
    repeat (10) @(posedge mclk_i);
    #1;
    check("reset ccr", {10'h0, ccr_o}, {10'h0, CCR_RESET});
    check("reset mode", {13'h0, mode_o}, {13'h0, OAD_M_IMP});
    check("reset rd", {15'h0, mem_rd_o}, 16'h0000);
    rstn_i = 1'b1;
    pc = PC_RESET;
    foreach (rows[i])
    begin
      wait_valid();
      check("opcode", {8'h00, opcode_o}, {8'h00, rows[i].op});
      check("mode", {13'h0, mode_o}, {13'h0, rows[i].mode});
      check("length", {14'h0, length_o}, {14'h0, rows[i].len});
      check("ea", ea_o, exp_ea(rows[i], pc));
      check("pc", pc_o, pc);
      check("cycles", {15'h0, cycles_o > 8'h01}, 16'h0000);
      if (rows[i].mode == OAD_M_ACC)
      begin
        check("acc sel", {15'h0, acc_sel_o}, {15'h0, rows[i].op[4]});
        check("acc operand", operand_o,
              {8'h00, rows[i].op[4] ? ACC_B : ACC_A});
      end
      if (rows[i].mode == OAD_M_IMM)
        check("imm operand", operand_o, (rows[i].len == LEN_THREE) ?
              {rows[i].b2, rows[i].b3} : {8'h00, rows[i].b2});
      pc = pc + {14'h0, rows[i].len};
    end
    foreach (alus[i])
    begin
      alu_valid_i = 1'b1;
      alu_op_i = alus[i].op;
      alu_a_i = alus[i].a;
      alu_b_i = alus[i].b;
      flag_ctl_i = alus[i].ctl;
      step();
      alu_valid_i = 1'b0;
      check("result", {8'h00, alu_result_o}, {8'h00, alus[i].res});
      check("ccr", {10'h0, ccr_o}, {10'h0, alus[i].ccr});
      step();
    end
    pc_load_val_i = 16'h0040;
    pc_load_i = 1'b1;
    wait_valid();
    pc_load_i = 1'b0;
    wait_valid();
    check("loaded pc", pc_o, 16'h0040);
    rstn_i = 1'b0;
    step();
    check("rereset ccr", {10'h0, ccr_o}, {10'h0, CCR_RESET});
    check("rereset valid", {15'h0, decode_valid_o}, 16'h0000);
    rstn_i = 1'b1;
    for (int n = 0; n < 10 && mem_rd_o !== 1'b1; n++)
      step();
    check("first fetch", mem_addr_o, PC_RESET);
    wrap_up();
  end
endmodule
